// ===== core/ctmw_regs.vh
// register map, field positions and timing constants of the transceiver mode and wake block
`ifndef CTMW_REGS_VH
`define CTMW_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define CTMW_OFF_CTRL        12'h000
`define CTMW_OFF_STAT        12'h004
`define CTMW_OFF_SBC         12'h008

// ************************************************************
// transceiver mode codes
// ************************************************************
`define CTMW_MODE_OFF        2'h0
`define CTMW_MODE_WAKE       2'h1
`define CTMW_MODE_RXONLY     2'h2
`define CTMW_MODE_NORMAL     2'h3

// ************************************************************
// chip operating mode codes
// ************************************************************
`define CTMW_SBC_NORMAL      3'h0
`define CTMW_SBC_STOP        3'h1
`define CTMW_SBC_SLEEP       3'h2
`define CTMW_SBC_RESTART     3'h3
`define CTMW_SBC_FAILSAFE    3'h4

// ************************************************************
// status field positions
// ************************************************************
`define CTMW_ST_WAKE_BIT     2
`define CTMW_ST_TXTO_BIT     3
`define CTMW_ST_CLAMP_BIT    4
`define CTMW_ST_ARMED_BIT    5
`define CTMW_ST_READY_BIT    6
`define CTMW_ST_FAIL_BIT     7

// ************************************************************
// timing in ns and derived cycle counts at 5 ns
// ************************************************************
`define CTMW_CLK_NS          5
`define CTMW_EN_TIME_NS      20000
`define CTMW_WAKE_MIN_NS     500
`define CTMW_WAKE_MAX_NS     1800000
`define CTMW_TXTO_NS         2000000
`define CTMW_CLAMP_NS        2000000
`define CTMW_EN_CYC          ((`CTMW_EN_TIME_NS + `CTMW_CLK_NS - 1) / `CTMW_CLK_NS)
`define CTMW_WAKE_MIN_CYC    ((`CTMW_WAKE_MIN_NS + `CTMW_CLK_NS - 1) / `CTMW_CLK_NS)
`define CTMW_WAKE_MAX_CYC    (`CTMW_WAKE_MAX_NS / `CTMW_CLK_NS)
`define CTMW_TXTO_CYC        (`CTMW_TXTO_NS / `CTMW_CLK_NS)
`define CTMW_CLAMP_CYC       (`CTMW_CLAMP_NS / `CTMW_CLK_NS)

`endif

// ===== core/ctmw_top.v
// transceiver mode control, enable settling, wake pattern detection and fault timing
`timescale 1ns/1ps
// What this block does
// R01: reset starts in off mode; off is allowed in every chip mode, stopping bus activity.
// R02: in off mode bus activity raises no wake indication.
// R03: transceiver mode is chosen by writing the mode bits over the register bus.
// R04: normal mode is granted only in chip normal or stop mode.
// R05: host enables normal mode by a command while chip is in normal mode.
// R06: after enabling normal mode, dominant transmit is held off for a settling time.
// R07: host returns transmit input high if it went low during settling.
// R08: a dominant level present at settling end is not sent; only a fresh one.
// R09: in normal mode the driver follows the transmit input.
// R10: in normal and receive-only modes the receive output shows the bus comparison.
// R11: receive-only mode disables the driver; reception continues.
// R12: receive-only mode is granted only in chip normal or stop mode.
// R13: wake capable mode is selectable in stop, sleep, restart and normal chip modes.
// R14: entering fail-safe forces wake capable mode.
// R15: a valid wake pattern pulls receive low until the mode changes.
// R16: wake pattern has two dominant phases each within the min and max window.
// R17: the dominant phases are split by a recessive phase within the same window.
// R18: phases are timed by a counter; an out-of-window phase restarts the search.
// R19: after a bus wake the mode bits keep reading the wake capable code.
// R20: wake is re-armed by toggling the mode away or entering stop or fail-safe.
// R21: transmit dominant beyond timeout disables driver, sets fault, resumes once transmit goes high.
// R22: in normal and receive-only modes, bus dominant beyond clamp timeout sets fault and keeps the mode unchanged.
`include "ctmw_regs.vh"

module ctmw_top #(
   parameter EN_CYC      = `CTMW_EN_CYC,
   parameter WAKE_MIN    = `CTMW_WAKE_MIN_CYC,
   parameter WAKE_MAX    = `CTMW_WAKE_MAX_CYC,
   parameter TXTO_CYC    = `CTMW_TXTO_CYC,
   parameter CLAMP_CYC   = `CTMW_CLAMP_CYC
) (
   // clock and reset
   input  wire        I_CLK_SYS,
   input  wire        I_RST,
   // axi4-lite write address and data
   input  wire [11:0] I_AWADDR,
   input  wire        I_AWVALID,
   output wire        O_AWREADY,
   input  wire [31:0] I_WDATA,
   input  wire [3:0]  I_WSTRB,
   input  wire        I_WVALID,
   output wire        O_WREADY,
   output wire [1:0]  O_BRESP,
   output wire        O_BVALID,
   input  wire        I_BREADY,
   // axi4-lite read
   input  wire [11:0] I_ARADDR,
   input  wire        I_ARVALID,
   output wire        O_ARREADY,
   output wire [31:0] O_RDATA,
   output wire [1:0]  O_RRESP,
   output wire        O_RVALID,
   input  wire        I_RREADY,
   // chip operating mode from the system state machine
   input  wire [2:0]  I_SBC_MODE,
   // protocol controller pins
   input  wire        I_TX_DATA_IN,
   output wire        O_RX_DATA,
   // bus side: comparator result (high = recessive) and driver control
   input  wire        I_BUS_RX,
   output wire        O_BUS_DOMINANT,
   output wire        O_BUS_BIAS_EN
);

   // ************************************************************
   // input synchronisers
   // ************************************************************
   reg  [1:0] tx_s_r;
   reg  [1:0] bus_s_r;
   reg  [2:0] sbc_m1_r;
   reg  [2:0] sbc_m2_r;
   reg  [2:0] sbc_m3_r;
   wire       tx_in = tx_s_r[1];
   wire       bus_in = bus_s_r[1];

   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         tx_s_r   <= 2'h3;
         bus_s_r  <= 2'h3;
         sbc_m1_r <= 3'h0;
         sbc_m2_r <= 3'h0;
         sbc_m3_r <= 3'h0;
      end else begin
         tx_s_r   <= {tx_s_r[0], I_TX_DATA_IN};
         bus_s_r  <= {bus_s_r[0], I_BUS_RX};
         sbc_m1_r <= I_SBC_MODE;
         sbc_m2_r <= sbc_m1_r;
         sbc_m3_r <= sbc_m2_r;
      end
   end

   // ************************************************************
   // mode permission
   // ************************************************************
   function allowed;
      input [1:0] m;
      input [2:0] s;
      begin
         case (m)
            `CTMW_MODE_OFF:    allowed = 1'b1;                          // [R01]
            `CTMW_MODE_WAKE:   allowed = (s != `CTMW_SBC_FAILSAFE);      // [R13]
            default:           allowed = (s == `CTMW_SBC_NORMAL) ||
                                         (s == `CTMW_SBC_STOP);          // [R04] [R12]
         endcase
      end
   endfunction

   // ************************************************************
   // register bus slave
   // ************************************************************
   reg        aw_got_r;
   reg        w_got_r;
   reg [11:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0]  w_strb_r;
   reg        bvalid_r;
   reg [1:0]  bresp_r;
   reg        rvalid_r;
   reg [1:0]  rresp_r;
   reg [31:0] rdata_r;
   reg [1:0]  mode_r;
   reg [2:0]  sbc_prev_r;
   reg        wake_r;
   reg        armed_r;
   reg        txto_r;
   reg        clamp_r;
   reg        fail_r;
   reg        en_done_r;
   // the mode word is used only once two samples agree
   wire [2:0] sbc = (sbc_m2_r == sbc_m3_r) ? sbc_m3_r : sbc_prev_r;

   assign O_AWREADY = !aw_got_r && !bvalid_r;
   assign O_WREADY  = !w_got_r && !bvalid_r;
   assign O_ARREADY = !rvalid_r;
   assign O_BVALID  = bvalid_r;
   assign O_BRESP   = bresp_r;
   assign O_RVALID  = rvalid_r;
   assign O_RRESP   = rresp_r;
   assign O_RDATA   = rdata_r;

   wire       aw_fire = I_AWVALID && O_AWREADY;
   wire       w_fire  = I_WVALID && O_WREADY;
   wire       aw_have = aw_got_r || aw_fire;
   wire       w_have  = w_got_r || w_fire;
   wire [11:0] wa     = aw_got_r ? aw_addr_r : I_AWADDR;
   wire [31:0] wd     = w_got_r ? w_data_r : I_WDATA;
   wire [3:0]  ws     = w_got_r ? w_strb_r : I_WSTRB;
   wire        do_wr  = aw_have && w_have && !bvalid_r;
   wire        ctrl_wr = do_wr && (wa == `CTMW_OFF_CTRL) && ws[0];
   wire        fclr_wr = do_wr && (wa == `CTMW_OFF_STAT) && ws[0] && wd[`CTMW_ST_FAIL_BIT];
   wire [1:0]  req_mode = wd[1:0];
   wire        mode_ok  = allowed(req_mode, sbc);

   wire [31:0] stat_word = {24'h000000, fail_r, en_done_r, armed_r, clamp_r, txto_r, wake_r, mode_r};

   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r  <= 32'h00000000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'h0;
         rvalid_r  <= 1'b0;
         rresp_r   <= 2'h0;
         rdata_r   <= 32'h00000000;
      end else begin
         if (aw_fire) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= I_AWADDR;
         end
         if (w_fire) begin
            w_got_r  <= 1'b1;
            w_data_r <= I_WDATA;
            w_strb_r <= I_WSTRB;
         end
         if (do_wr) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            if (wa == `CTMW_OFF_CTRL || wa == `CTMW_OFF_STAT)
               bresp_r <= (wa == `CTMW_OFF_CTRL && ws[0] && !mode_ok) ? 2'h2 : 2'h0;
            else
               bresp_r <= 2'h2;
         end else if (bvalid_r && I_BREADY) begin
            bvalid_r <= 1'b0;
         end
         if (I_ARVALID && O_ARREADY) begin
            rvalid_r <= 1'b1;
            rresp_r  <= 2'h0;
            case (I_ARADDR)
               `CTMW_OFF_CTRL: rdata_r <= {30'h00000000, mode_r};  // [R19]
               `CTMW_OFF_STAT: rdata_r <= stat_word;
               `CTMW_OFF_SBC:  rdata_r <= {29'h00000000, sbc};
               default: begin
                  rdata_r <= 32'h00000000;
                  rresp_r <= 2'h2;
               end
            endcase
         end else if (rvalid_r && I_RREADY) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // mode register
   // ************************************************************
   // refused modes keep the old value; fail-safe overrides any write
   wire entering_fs   = (sbc == `CTMW_SBC_FAILSAFE) && (sbc_prev_r != `CTMW_SBC_FAILSAFE);
   wire entering_stop = (sbc == `CTMW_SBC_STOP) && (sbc_prev_r != `CTMW_SBC_STOP);
   reg [1:0] mode_nxt;

   always @* begin
      mode_nxt = mode_r;
      if (ctrl_wr && mode_ok)
         mode_nxt = req_mode;                                           // [R03] [R05]
      if (sbc == `CTMW_SBC_FAILSAFE)
         mode_nxt = `CTMW_MODE_WAKE;                                    // [R14]
      if (!allowed(mode_r, sbc) && mode_nxt == mode_r && sbc != `CTMW_SBC_FAILSAFE)
         mode_nxt = `CTMW_MODE_WAKE;
   end

   wire mode_chg = (mode_nxt != mode_r);

   // ************************************************************
   // enable settling and transmit path
   // ************************************************************
   reg [31:0] en_cnt_r;
   reg        fresh_r;
   reg [31:0] txto_cnt_r;
   reg [31:0] clamp_cnt_r;
   wire       is_norm = (mode_r == `CTMW_MODE_NORMAL);
   wire       is_rxo  = (mode_r == `CTMW_MODE_RXONLY);

   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         mode_r      <= `CTMW_MODE_OFF;                                 // [R01]
         sbc_prev_r  <= 3'h0;
         en_cnt_r    <= 32'h00000000;
         en_done_r   <= 1'b0;
         fresh_r     <= 1'b0;
         txto_cnt_r  <= 32'h00000000;
         txto_r      <= 1'b0;
         clamp_cnt_r <= 32'h00000000;
         clamp_r     <= 1'b0;
         fail_r      <= 1'b0;
      end else begin
         mode_r     <= mode_nxt;
         sbc_prev_r <= sbc;
         if (!is_norm || mode_chg) begin
            en_cnt_r  <= 32'h00000000;
            en_done_r <= 1'b0;
            fresh_r   <= 1'b0;
         end else if (!en_done_r) begin
            if (en_cnt_r >= EN_CYC - 1)
               en_done_r <= 1'b1;                                       // [R06]
            en_cnt_r <= en_cnt_r + 32'h1;
         end else if (tx_in) begin
            fresh_r <= 1'b1;                                            // [R08]
         end
         if (is_norm && !tx_in) begin
            if (txto_cnt_r < TXTO_CYC)
               txto_cnt_r <= txto_cnt_r + 32'h1;
         end else begin
            txto_cnt_r <= 32'h00000000;
         end
         txto_r <= is_norm && !tx_in && (txto_cnt_r >= TXTO_CYC);       // [R21]
         if ((is_norm || is_rxo) && !bus_in) begin
            if (clamp_cnt_r < CLAMP_CYC)
               clamp_cnt_r <= clamp_cnt_r + 32'h1;
         end else begin
            clamp_cnt_r <= 32'h00000000;
         end
         clamp_r <= (is_norm || is_rxo) && !bus_in && (clamp_cnt_r >= CLAMP_CYC); // [R22]
         if (txto_r || clamp_r)
            fail_r <= 1'b1;                                             // [R21] [R22]
         else if (fclr_wr)
            fail_r <= 1'b0;
      end
   end

   // ************************************************************
   // wake pattern detector
   // ************************************************************
   localparam WS_IDLE = 2'h0;
   localparam WS_DOM1 = 2'h1;
   localparam WS_REC  = 2'h2;
   localparam WS_DOM2 = 2'h3;
   reg [1:0]  ws_r;
   reg [31:0] ph_cnt_r;
   wire       in_win = (ph_cnt_r >= WAKE_MIN) && (ph_cnt_r < WAKE_MAX - 1);
   wire       hunt   = (mode_r == `CTMW_MODE_WAKE) && armed_r && !mode_chg;  // [R02]

   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         ws_r     <= WS_IDLE;
         ph_cnt_r <= 32'h00000000;
         wake_r   <= 1'b0;
         armed_r  <= 1'b1;
      end else begin
         if (mode_chg) begin
            wake_r  <= 1'b0;                                            // [R15]
            armed_r <= 1'b1;                                            // [R20]
         end else if (entering_stop || entering_fs) begin
            armed_r <= 1'b1;                                            // [R20]
         end
         if (!hunt) begin
            ws_r     <= WS_IDLE;
            ph_cnt_r <= 32'h00000000;
         end else begin
            if (ph_cnt_r < WAKE_MAX)
               ph_cnt_r <= ph_cnt_r + 32'h1;                            // [R18]
            case (ws_r)
               WS_IDLE: begin
                  ph_cnt_r <= 32'h00000000;
                  if (!bus_in)
                     ws_r <= WS_DOM1;
               end
               WS_DOM1, WS_DOM2: begin
                  if (bus_in) begin
                     ph_cnt_r <= 32'h00000000;
                     if (!in_win)
                        ws_r <= WS_IDLE;                                // [R18]
                     else if (ws_r == WS_DOM1)
                        ws_r <= WS_REC;                                 // [R16]
                     else begin
                        ws_r    <= WS_IDLE;
                        wake_r  <= 1'b1;                                // [R15] [R16]
                        armed_r <= 1'b0;                                // [R19]
                     end
                  end else if (ph_cnt_r >= WAKE_MAX) begin
                     ws_r <= WS_IDLE;                                   // [R18]
                  end
               end
               WS_REC: begin
                  if (!bus_in) begin
                     ph_cnt_r <= 32'h00000000;
                     ws_r <= in_win ? WS_DOM2 : WS_DOM1;                // [R17]
                  end else if (ph_cnt_r >= WAKE_MAX) begin
                     ws_r <= WS_IDLE;                                   // [R18]
                  end
               end
               default: ws_r <= WS_IDLE;
            endcase
         end
      end
   end

   // ************************************************************
   // pin outputs
   // ************************************************************
   reg dom_r;
   reg rx_r;
   reg bias_r;

   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         dom_r  <= 1'b0;
         rx_r   <= 1'b1;
         bias_r <= 1'b0;
      end else begin
         // a low already present at settling end waits for a high first
         dom_r  <= is_norm && en_done_r && fresh_r && !tx_in && !txto_r; // [R09] [R11] [R21]
         if (is_norm || is_rxo)
            rx_r <= bus_in;                                             // [R10]
         else if (mode_r == `CTMW_MODE_WAKE)
            rx_r <= !wake_r;                                            // [R15]
         else
            rx_r <= 1'b1;                                               // [R01]
         bias_r <= is_norm || is_rxo;
      end
   end

   assign O_BUS_DOMINANT = dom_r;
   assign O_RX_DATA      = rx_r;
   assign O_BUS_BIAS_EN  = bias_r;

endmodule

// ===== tb/ctmw_can_ctrl.sv
// protocol controller model that drives the transmit input and watches the receive output
`timescale 1ns/1ps
module ctmw_can_ctrl (
   // clock and pins
   input  wire  i_clk,
   input  wire  i_rx,
   output logic o_tx
);
   // ************************************************************
   // transmit driver and receive monitor
   // ************************************************************
   int rx_low = 0;
   initial o_tx = 1'b1;
   always @(posedge i_clk) begin
      if (i_rx === 1'b0)
         rx_low <= rx_low + 1;
   end
   // each bit lasts n cycles; ending recessive keeps an early dominant from lingering
   task automatic send(input logic [7:0] p, input int n);
      int i;
      begin
         for (i = 7; i >= 0; i--) begin
            @(posedge i_clk);
            o_tx <= p[i];
            repeat (n - 1) @(posedge i_clk);
         end
         @(posedge i_clk);
         o_tx <= 1'b1;
      end
   endtask
endmodule

// ===== tb/ctmw_monitor.sv
// port checker for the transceiver mode and wake block
`timescale 1ns/1ps
module ctmw_monitor #(
   parameter TXTO_CYC = 50
) (
   // clock and reset
   input wire        I_CLK_SYS,
   input wire        I_RST,
   // register bus
   input wire        I_AWVALID,
   input wire        O_AWREADY,
   input wire        I_WVALID,
   input wire        O_WREADY,
   input wire [1:0]  O_BRESP,
   input wire        O_BVALID,
   input wire        I_BREADY,
   input wire        I_ARVALID,
   input wire        O_ARREADY,
   input wire [31:0] O_RDATA,
   input wire        O_RVALID,
   input wire        I_RREADY,
   // pins
   input wire        I_TX_DATA_IN,
   input wire        O_RX_DATA,
   input wire        I_BUS_RX,
   input wire        O_BUS_DOMINANT,
   input wire        O_BUS_BIAS_EN
);
   // ************************************************************
   // helper counter and assertions
   // ************************************************************
   reg  [19:0] dom_run_r;
   wire [19:0] dom_run_nxt = O_BUS_DOMINANT ? dom_run_r + 20'h1 : 20'h0;
   always @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST)
         dom_run_r <= 20'h0;
      else
         dom_run_r <= dom_run_nxt;
   end
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);
   sequence s_wr_taken;
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
   endsequence
   sequence s_rd_taken;
      I_ARVALID && O_ARREADY;
   endsequence
   chk_write_answer: assert property (s_wr_taken |=> O_BVALID)
      else $error("write response missing");
   chk_read_answer: assert property (s_rd_taken |=> O_RVALID)
      else $error("read response missing");
   chk_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped");
   chk_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped");
   chk_bias_gate: assert property (!O_BUS_BIAS_EN && $past(!O_BUS_BIAS_EN) |-> !O_BUS_DOMINANT)
      else $error("driver active while unbiased");
   chk_dom_cause: assert property ($rose(O_BUS_DOMINANT) |-> !$past(I_TX_DATA_IN, 3))
      else $error("dominant without transmit low");
   chk_dom_release: assert property ($rose(I_TX_DATA_IN) |-> ##[1:3] !O_BUS_DOMINANT)
      else $error("dominant after transmit high");
   chk_rx_follow: assert property (O_BUS_BIAS_EN && $past(O_BUS_BIAS_EN) && $past(O_BUS_BIAS_EN, 2)
      |-> O_RX_DATA == $past(I_BUS_RX, 3))
      else $error("receive output not following bus");
   chk_txto_limit: assert property (dom_run_r <= TXTO_CYC + 4)
      else $error("dominant beyond transmit timeout");
endmodule

bind ctmw_top ctmw_monitor #(.TXTO_CYC(TXTO_CYC)) u_mon (
   .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
   .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
   .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
   .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .I_TX_DATA_IN(I_TX_DATA_IN), .O_RX_DATA(O_RX_DATA),
   .I_BUS_RX(I_BUS_RX), .O_BUS_DOMINANT(O_BUS_DOMINANT), .O_BUS_BIAS_EN(O_BUS_BIAS_EN)
);

// ===== tb/tb.sv
// self-checking bench for the transceiver mode and wake block
`timescale 1ns/1ps
`include "ctmw_regs.vh"
module tb;
   // ************************************************************
   // clock, reset, hookup and shared tasks
   // ************************************************************
   localparam int EN = 20;
   localparam int WMIN = 4;
   localparam int WMAX = 40;
   localparam int TXTO = 50;
   localparam int CLAMP = 50;
   localparam int PH = 2 * WMIN + 2;
   localparam logic [11:0] CTRL = `CTMW_OFF_CTRL;
   localparam logic [11:0] STAT = `CTMW_OFF_STAT;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] awaddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic [11:0] araddr = 12'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [2:0]  sbc = 3'h0;
   logic        ext_d = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, tx, rx, dom, bias;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire         bus_rx = !(dom | ext_d);
   int          mismatches = 0;
   int          compares = 0;
   int          dom_cnt = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (dom === 1'b1)
         dom_cnt <= dom_cnt + 1;
   end
   ctmw_top #(.EN_CYC(EN), .WAKE_MIN(WMIN), .WAKE_MAX(WMAX), .TXTO_CYC(TXTO), .CLAMP_CYC(CLAMP)) uut (
      .I_CLK_SYS(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_SBC_MODE(sbc),
      .I_TX_DATA_IN(tx), .O_RX_DATA(rx), .I_BUS_RX(bus_rx), .O_BUS_DOMINANT(dom), .O_BUS_BIAS_EN(bias));
   ctmw_can_ctrl ctl (.i_clk(clk), .i_rx(rx), .o_tx(tx));
   task automatic wrap_up;
      begin
         $display("compares %0d mismatches %0d", compares, mismatches);
         if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ready is judged at the falling edge, clear of the rising edge updates
   task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      int n;
      logic ta, tw, tr, dn;
      begin
         dn = 1'b0;
         @(posedge clk);
         awaddr <= a;
         wdata <= d;
         araddr <= a;
         awvalid <= we;
         wvalid <= we;
         arvalid <= !we;
         bready <= we;
         rready <= !we;
         for (n = 0; n < 50 && !dn; n++) begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tr = arvalid & arready;
            dn = we ? bvalid & bready : rvalid & rready;
            q = rdata;
            r = we ? bresp : rresp;
            @(posedge clk);
            if (ta)
               awvalid <= 1'b0;
            if (tw)
               wvalid <= 1'b0;
            if (tr)
               arvalid <= 1'b0;
            bready <= we & !dn;
            rready <= !we & !dn;
         end
         if (!dn) begin
            $display("unexpected at %0t: bus access hung", $time);
            mismatches++;
            wrap_up;
         end
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      begin
         acc(1'b1, a, d, q, r);
         chk(r, er);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      begin
         acc(1'b0, a, 32'h0, q, r);
         chk(q & m, e);
         chk(r, er);
      end
   endtask
   task automatic ext(input int n);
      @(posedge clk);
      ext_d <= 1'b1;
      repeat (n) @(posedge clk);
      ext_d <= 1'b0;
      cyc(6);
   endtask
   // the long recessive tail lets the detector give up between patterns
   task automatic wake_pattern(input int d1, input int g, input int d2);
      @(posedge clk);
      ext_d <= 1'b1;
      repeat (d1) @(posedge clk);
      ext_d <= 1'b0;
      repeat (g) @(posedge clk);
      ext_d <= 1'b1;
      repeat (d2) @(posedge clk);
      ext_d <= 1'b0;
      cyc(WMAX + 20);
   endtask
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      int s, m, e, d0, x0;
      logic ok;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      cyc(3);
      chk(rx, 1'b1);
      chk(bias, 1'b0);
      rd(CTRL, 32'h3, `CTMW_MODE_OFF, 2'h0);
      rd(12'h00c, 32'hffffffff, 32'h0, 2'h2);
      wr(12'h00c, 32'h0, 2'h2);
      $display("test reset done");
      for (s = 0; s < 4; s++) begin
         sbc <= s[2:0];
         cyc(4);
         e = 0;
         for (m = 0; m < 4; m++) begin
            ok = (m < 2) || (s < 2);
            wr(CTRL, m, ok ? 2'h0 : 2'h2);
            if (ok)
               e = m;
            rd(CTRL, 32'h3, e, 2'h0);
         end
         wr(CTRL, `CTMW_MODE_OFF, 2'h0);
      end
      sbc <= `CTMW_SBC_FAILSAFE;
      cyc(4);
      rd(CTRL, 32'h3, `CTMW_MODE_WAKE, 2'h0);
      sbc <= `CTMW_SBC_NORMAL;
      cyc(4);
      $display("test mode table done");
      wr(CTRL, `CTMW_MODE_NORMAL, 2'h0);
      d0 = dom_cnt;
      ctl.send(8'h00, EN / 8 + 2);
      cyc(6);
      chk(dom_cnt - d0, 0);
      d0 = dom_cnt;
      x0 = ctl.rx_low;
      ctl.send(8'h0f, 4);
      cyc(6);
      chk(dom_cnt - d0, 16);
      chk(ctl.rx_low - x0, 16);
      d0 = dom_cnt;
      ctl.send(8'h00, TXTO / 8 + 3);
      cyc(6);
      chk((dom_cnt - d0 > TXTO - 6) && (dom_cnt - d0 < TXTO + 6), 1);
      rd(STAT, 32'h83, 32'h83, 2'h0);
      d0 = dom_cnt;
      ctl.send(8'h0f, 4);
      cyc(6);
      chk(dom_cnt - d0, 16);
      wr(STAT, 32'h80, 2'h0);
      rd(STAT, 32'h80, 32'h0, 2'h0);
      $display("test normal done");
      wr(CTRL, `CTMW_MODE_RXONLY, 2'h0);
      d0 = dom_cnt;
      x0 = ctl.rx_low;
      ctl.send(8'h0f, 4);
      ext(8);
      chk(bias, 1'b1);
      chk(dom_cnt - d0, 0);
      chk(ctl.rx_low - x0, 8);
      ext(CLAMP + 10);
      rd(STAT, 32'h83, 32'h82, 2'h0);
      $display("test receive only done");
      wr(CTRL, `CTMW_MODE_WAKE, 2'h0);
      wake_pattern(PH, PH, PH);
      chk(rx, 1'b0);
      cyc(20);
      chk(rx, 1'b0);
      rd(CTRL, 32'h3, `CTMW_MODE_WAKE, 2'h0);
      wr(CTRL, `CTMW_MODE_OFF, 2'h0);
      cyc(4);
      chk(rx, 1'b1);
      wr(CTRL, `CTMW_MODE_WAKE, 2'h0);
      wake_pattern(WMIN - 2, PH, PH);
      chk(rx, 1'b1);
      wake_pattern(WMAX + 5, PH, PH);
      chk(rx, 1'b1);
      wake_pattern(PH, WMAX + 10, PH);
      chk(rx, 1'b1);
      wake_pattern(PH, PH, PH);
      chk(rx, 1'b0);
      sbc <= `CTMW_SBC_STOP;
      cyc(4);
      rd(STAT, 32'h20, 32'h20, 2'h0);
      sbc <= `CTMW_SBC_NORMAL;
      wr(CTRL, `CTMW_MODE_OFF, 2'h0);
      d0 = dom_cnt;
      ctl.send(8'h00, 2);
      wake_pattern(PH, PH, PH);
      chk(rx, 1'b1);
      chk(dom_cnt - d0, 0);
      $display("test wake done");
      wrap_up;
   end
endmodule
